// ### design/hts_top.sv
/*
  Homing and target start sequencer: picks a stored destination from the
  select inputs, starts it on a start edge, runs the homing search and
  drives a velocity command. Assumes synchronous inputs, an encoder
  position input, and an Avalon-MM master for configuration.
*/
`timescale 1ns/10ps
module hts_top #(
  parameter logic [31:0] STOP_HOLD = hts_pkg::STOP_HOLD_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Avalon-MM slave
  input wire logic [9:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [31:0] WRITEDATA,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // Controller inputs
  input wire logic [5:0] DEST_SELECT_IN,
  input wire logic POSITION_START_IN,
  input wire logic ENABLE_IN,
  // Axis feedback
  input wire logic NEG_LIMIT_IN,
  input wire logic POS_LIMIT_IN,
  input wire logic STOP_DETECT_IN,
  input wire logic INDEX_PULSE_IN,
  input wire logic [31:0] ACTUAL_POS_IN,
  // Motion command
  output logic signed [16:0] VEL_CMD_OUT,
  output logic [31:0] TARGET_POS_OUT,
  output logic [5:0] DEST_INDEX_OUT,
  // Indications
  output logic TARGET_REACHED_OUT,
  output logic REMAIN_DIST_OUT,
  output logic HOMING_DONE_OUT,
  output logic HOMING_BUSY_OUT,
  output logic HOMING_ERROR_OUT,
  output logic ZERO_SET_OUT
);

  hts_pkg::hts_state_t s_q;
  hts_pkg::hts_state_t s_d;

  logic req;
  logic acc_wr;
  logic tick;
  logic home_go;
  logic start_edge;
  logic neg_dir;
  logic idx_meth;
  logic srch_lim;
  logic pmode;
  logic brake;
  logic [15:0] vlim;
  logic [15:0] accl;
  logic [15:0] step;
  logic [15:0] ac;
  logic [16:0] vabs;
  logic signed [16:0] setv;
  logic signed [17:0] dv;
  logic signed [32:0] rem;
  logic [32:0] remabs;
  logic [32:0] srch_dist;
  logic [31:0] sdiff;
  logic [49:0] vsq;
  logic [49:0] bdist;
  logic [31:0] wdm;
  logic [31:0] rd;

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, write and read data at the ack edge

  assign req = READ | WRITE;
  assign WAITREQUEST = req & ~s_q.ack;
  assign acc_wr = WRITE & s_q.ack;

  always_comb begin
    rd = 32'h0;
    unique case (ADDRESS)
      hts_pkg::A_CTRL: begin
        rd[hts_pkg::C_HOME_AT_EN] = s_q.cfg.home_at_en;
        rd[hts_pkg::C_GO_ZERO] = s_q.cfg.go_zero;
        rd[hts_pkg::C_STOP_VAR] = s_q.cfg.stop_var;
      end
      hts_pkg::A_STATUS: begin
        rd = {18'h0, s_q.act_sel, 2'h0, s_q.remain, s_q.reached,
              s_q.moving, s_q.home_err, (s_q.hs != hts_pkg::HS_IDLE),
              s_q.home_done};
      end
      hts_pkg::A_METHOD: rd = {24'h0, s_q.cfg.method};
      hts_pkg::A_OFFSET: rd = s_q.cfg.offset;
      hts_pkg::A_MAXSRCH: rd = s_q.cfg.max_search;
      hts_pkg::A_SRCH_V: rd = {16'h0, s_q.cfg.srch_v};
      hts_pkg::A_CRAWL_V: rd = {16'h0, s_q.cfg.crawl_v};
      hts_pkg::A_RUN_V: rd = {16'h0, s_q.cfg.run_v};
      hts_pkg::A_HOME_ACC: rd = {16'h0, s_q.cfg.home_acc};
      hts_pkg::A_POS_V: rd = {16'h0, s_q.cfg.pos_v};
      hts_pkg::A_POS_ACC: rd = {16'h0, s_q.cfg.pos_acc};
      hts_pkg::A_JERK: rd = {28'h0, s_q.cfg.jerk_sh};
      hts_pkg::A_REMAIN: rd = s_q.cfg.remain_thr;
      hts_pkg::A_ORIGIN: rd = s_q.origin;
      default: begin
        if (ADDRESS[9:8] == hts_pkg::A_DEST_PAGE) begin
          rd = s_q.dest[ADDRESS[7:2]];
        end
      end
    endcase
  end

  // Home start bit is a write-one pulse, never stored
  assign home_go = acc_wr && ADDRESS == hts_pkg::A_CTRL && BYTEENABLE[0]
                   && WRITEDATA[hts_pkg::C_HOME_GO];

  ////////////////////////////////////////////////////////////////////
  // Profile tick, method decode and motion engine operands

  assign tick = s_q.tick_cnt == 8'(hts_pkg::TICK_CYC - 1);
  assign start_edge = s_q.start_s & ~s_q.start_prev;

  // Codes compared as the standard numbers so bus values carry over
  assign neg_dir = s_q.cfg.method == hts_pkg::M_NEG_IDX
                   || s_q.cfg.method == hts_pkg::M_NEG_SW
                   || s_q.cfg.method == hts_pkg::M_IDX_NEG;
  assign idx_meth = s_q.cfg.method == hts_pkg::M_NEG_IDX
                    || s_q.cfg.method == hts_pkg::M_POS_IDX;
  assign srch_lim = neg_dir ? NEG_LIMIT_IN : POS_LIMIT_IN;

  assign rem = 33'(signed'({s_q.target[31], s_q.target}))
               - 33'(signed'({ACTUAL_POS_IN[31], ACTUAL_POS_IN}));
  assign remabs = rem[32] ? 33'(-rem) : 33'(rem);
  // Wrapped difference, so a search across zero keeps its true length
  assign sdiff = ACTUAL_POS_IN - s_q.start_pos;
  assign srch_dist = sdiff[31] ? {1'b0, -sdiff} : {1'b0, sdiff};
  assign vabs = s_q.vel[16] ? 17'(-s_q.vel) : 17'(s_q.vel);
  assign vsq = 50'(vabs) * 50'(vabs);
  assign bdist = 50'(accl) * 50'(remabs) * 50'h2;
  assign brake = vsq >= bdist;

  // Homing takes its own speed set, moves take theirs
  always_comb begin
    pmode = 1'b0;
    vlim = 16'h0;
    accl = s_q.cfg.pos_acc;
    setv = 17'sh0;
    unique case (s_q.hs)
      hts_pkg::HS_SEARCH: begin
        vlim = s_q.cfg.srch_v;
        accl = s_q.cfg.home_acc;
        setv = neg_dir ? -17'(signed'({1'b0, vlim}))
                       : 17'(signed'({1'b0, vlim}));
      end
      hts_pkg::HS_CRAWL, hts_pkg::HS_INDEX: begin
        vlim = s_q.cfg.crawl_v;
        accl = s_q.cfg.home_acc;
        setv = neg_dir ? 17'(signed'({1'b0, vlim}))
                       : -17'(signed'({1'b0, vlim}));
      end
      hts_pkg::HS_GOZERO: begin
        pmode = 1'b1;
        vlim = s_q.cfg.run_v;
        accl = s_q.cfg.home_acc;
      end
      default: begin
        pmode = s_q.moving;
        vlim = s_q.cfg.pos_v;
      end
    endcase
    if (pmode) begin
      if (brake) begin
        setv = 17'sh0;
      end else begin
        setv = rem[32] ? -17'(signed'({1'b0, vlim}))
                       : 17'(signed'({1'b0, vlim}));
      end
    end
  end

  // Jerk filter grows the applied acceleration over 2^n ticks
  assign step = s_q.cfg.jerk_sh == 4'h0 ? accl
                : ((accl >> s_q.cfg.jerk_sh) == 16'h0 ? 16'h1
                   : accl >> s_q.cfg.jerk_sh);
  assign ac = (17'(s_q.acc_cur) + 17'(step) > 17'(accl))
              ? accl : 16'(s_q.acc_cur + step);
  assign dv = 18'(setv) - 18'(s_q.vel);

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    s_d.zero_pulse = 1'b0;
    s_d.ack = req & ~s_q.ack;
    s_d.tick_cnt = tick ? 8'h0 : 8'(s_q.tick_cnt + 8'h1);
    s_d.sel = DEST_SELECT_IN;
    s_d.start_s = POSITION_START_IN;
    s_d.start_prev = s_q.start_s;
    s_d.en_prev = ENABLE_IN;
    if (req & ~s_q.ack) begin
      s_d.rdata = rd;
    end

    // Register writes
    wdm = WRITEDATA;
    if (acc_wr) begin
      wdm = be_merge(rd, WRITEDATA, BYTEENABLE);
      unique case (ADDRESS)
        hts_pkg::A_CTRL: begin
          s_d.cfg.home_at_en = wdm[hts_pkg::C_HOME_AT_EN];
          s_d.cfg.go_zero = wdm[hts_pkg::C_GO_ZERO];
          s_d.cfg.stop_var = wdm[hts_pkg::C_STOP_VAR];
        end
        hts_pkg::A_METHOD: s_d.cfg.method = wdm[7:0];
        hts_pkg::A_OFFSET: s_d.cfg.offset = wdm;
        hts_pkg::A_MAXSRCH: s_d.cfg.max_search = wdm;
        hts_pkg::A_SRCH_V: s_d.cfg.srch_v = wdm[15:0];
        hts_pkg::A_CRAWL_V: s_d.cfg.crawl_v = wdm[15:0];
        hts_pkg::A_RUN_V: s_d.cfg.run_v = wdm[15:0];
        hts_pkg::A_HOME_ACC: s_d.cfg.home_acc = wdm[15:0];
        hts_pkg::A_POS_V: s_d.cfg.pos_v = wdm[15:0];
        hts_pkg::A_POS_ACC: s_d.cfg.pos_acc = wdm[15:0];
        hts_pkg::A_JERK: s_d.cfg.jerk_sh = wdm[3:0];
        hts_pkg::A_REMAIN: s_d.cfg.remain_thr = wdm;
        default: begin
          if (ADDRESS[9:8] == hts_pkg::A_DEST_PAGE) begin
            s_d.dest[ADDRESS[7:2]] = wdm;
          end
        end
      endcase
    end

    // Destination start; refused while homing runs
    if (start_edge && ENABLE_IN && s_q.hs == hts_pkg::HS_IDLE) begin
      s_d.act_sel = s_q.sel;
      s_d.target = s_q.origin + s_q.dest[s_q.sel];
      s_d.moving = 1'b1;
      s_d.reached = 1'b0;
    end

    // Homing sequence
    unique case (s_q.hs)
      hts_pkg::HS_IDLE: begin
        if (ENABLE_IN && (home_go || (s_q.cfg.home_at_en
            && !s_q.en_prev))) begin
          s_d.home_done = 1'b0;
          s_d.home_err = 1'b0;
          s_d.moving = 1'b0;
          s_d.reached = 1'b0;
          s_d.stop_cnt = 32'h0;
          s_d.start_pos = ACTUAL_POS_IN;
          unique case (s_q.cfg.method)
            hts_pkg::M_NO_RUN: s_d.hs = hts_pkg::HS_ZERO;
            hts_pkg::M_IDX_NEG, hts_pkg::M_IDX_POS:
              s_d.hs = hts_pkg::HS_WAIT_IDX;
            hts_pkg::M_NEG_IDX, hts_pkg::M_POS_IDX,
            hts_pkg::M_NEG_SW, hts_pkg::M_POS_SW:
              s_d.hs = hts_pkg::HS_SEARCH;
            default: s_d.home_err = 1'b1;
          endcase
        end
      end
      hts_pkg::HS_SEARCH: begin
        s_d.stop_cnt = STOP_DETECT_IN ? s_q.stop_cnt + 32'h1 : 32'h0;
        if (srch_dist > 33'(s_q.cfg.max_search)) begin
          s_d.home_err = 1'b1;
          s_d.hs = hts_pkg::HS_IDLE;
        end else if (s_q.cfg.stop_var) begin
          if (STOP_DETECT_IN && s_q.stop_cnt >= STOP_HOLD - 32'h1) begin
            s_d.hs = idx_meth ? hts_pkg::HS_INDEX : hts_pkg::HS_ZERO;
          end
        end else if (srch_lim) begin
          s_d.hs = hts_pkg::HS_CRAWL;
        end
      end
      hts_pkg::HS_CRAWL: begin
        if (!srch_lim) begin
          s_d.hs = idx_meth ? hts_pkg::HS_INDEX : hts_pkg::HS_ZERO;
        end
      end
      hts_pkg::HS_INDEX, hts_pkg::HS_WAIT_IDX: begin
        if (INDEX_PULSE_IN) begin
          s_d.hs = hts_pkg::HS_ZERO;
        end
      end
      hts_pkg::HS_ZERO: begin
        s_d.origin = ACTUAL_POS_IN + s_q.cfg.offset;
        s_d.target = ACTUAL_POS_IN + s_q.cfg.offset;
        s_d.home_done = 1'b1;
        s_d.zero_pulse = 1'b1;
        s_d.hs = s_q.cfg.go_zero ? hts_pkg::HS_GOZERO
                                 : hts_pkg::HS_IDLE;
      end
      hts_pkg::HS_GOZERO: ;
      default: s_d.hs = hts_pkg::HS_IDLE;
    endcase

    // Velocity ramp per profile tick
    if (tick) begin
      if (pmode && remabs <= 33'(vabs)) begin
        s_d.vel = 17'sh0;
        s_d.acc_cur = 16'h0;
        if (s_q.hs == hts_pkg::HS_GOZERO) begin
          s_d.hs = hts_pkg::HS_IDLE;
        end else if (s_q.moving) begin
          s_d.moving = 1'b0;
          s_d.reached = 1'b1;
        end
      end else if (dv == 18'sh0) begin
        s_d.acc_cur = 16'h0;
      end else begin
        s_d.acc_cur = ac;
        if (dv > 18'(signed'({2'b00, ac}))) begin
          s_d.vel = 17'(s_q.vel + 17'(signed'({1'b0, ac})));
        end else if (dv < -18'(signed'({2'b00, ac}))) begin
          s_d.vel = 17'(s_q.vel - 17'(signed'({1'b0, ac})));
        end else begin
          s_d.vel = setv;
        end
      end
    end

    s_d.remain = s_q.moving
                 && remabs <= 33'(s_q.cfg.remain_thr);

    // Dropping the enable stops everything at once
    if (!ENABLE_IN) begin
      s_d.hs = hts_pkg::HS_IDLE;
      s_d.moving = 1'b0;
      s_d.remain = 1'b0;
      s_d.vel = 17'sh0;
      s_d.acc_cur = 16'h0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s_q <= '0;
      s_q.cfg <= hts_pkg::CFG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign READDATA = s_q.rdata;
  assign VEL_CMD_OUT = s_q.vel;
  assign TARGET_POS_OUT = s_q.target;
  assign DEST_INDEX_OUT = s_q.act_sel;
  assign TARGET_REACHED_OUT = s_q.reached;
  assign REMAIN_DIST_OUT = s_q.remain;
  assign HOMING_DONE_OUT = s_q.home_done;
  assign HOMING_BUSY_OUT = s_q.hs != hts_pkg::HS_IDLE;
  assign HOMING_ERROR_OUT = s_q.home_err;
  assign ZERO_SET_OUT = s_q.zero_pulse;

endmodule // hts_top

// ### design/hts_pkg.sv
/*
  Shared constants and carrier types of the homing and target start
  sequencer. Assumes a 250 MHz control clock.
*/
package hts_pkg;

  // Clock and time base
  localparam int CLK_NS = 4;
  localparam int CLK_KHZ = 250000;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int STOP_HOLD_MS = 1000;
  localparam logic [31:0] STOP_HOLD_CYC = 32'(CLK_KHZ * STOP_HOLD_MS);

  // Byte addresses
  localparam logic [9:0] A_CTRL = 10'h000;
  localparam logic [9:0] A_STATUS = 10'h004;
  localparam logic [9:0] A_METHOD = 10'h008;
  localparam logic [9:0] A_OFFSET = 10'h00c;
  localparam logic [9:0] A_MAXSRCH = 10'h010;
  localparam logic [9:0] A_SRCH_V = 10'h014;
  localparam logic [9:0] A_CRAWL_V = 10'h018;
  localparam logic [9:0] A_RUN_V = 10'h01c;
  localparam logic [9:0] A_HOME_ACC = 10'h020;
  localparam logic [9:0] A_POS_V = 10'h024;
  localparam logic [9:0] A_POS_ACC = 10'h028;
  localparam logic [9:0] A_JERK = 10'h02c;
  localparam logic [9:0] A_REMAIN = 10'h030;
  localparam logic [9:0] A_ORIGIN = 10'h034;
  localparam logic [1:0] A_DEST_PAGE = 2'h1;

  // Control bit positions
  localparam int C_HOME_GO = 0;
  localparam int C_HOME_AT_EN = 1;
  localparam int C_GO_ZERO = 2;
  localparam int C_STOP_VAR = 3;

  // Homing method codes, standard motion-profile numbers
  localparam logic [7:0] M_NEG_IDX = 8'h01;
  localparam logic [7:0] M_POS_IDX = 8'h02;
  localparam logic [7:0] M_NEG_SW = 8'h11;
  localparam logic [7:0] M_POS_SW = 8'h12;
  localparam logic [7:0] M_IDX_NEG = 8'h21;
  localparam logic [7:0] M_IDX_POS = 8'h22;
  localparam logic [7:0] M_NO_RUN = 8'h23;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_SEARCH = 3'b001,
    HS_CRAWL = 3'b010,
    HS_INDEX = 3'b011,
    HS_WAIT_IDX = 3'b100,
    HS_ZERO = 3'b101,
    HS_GOZERO = 3'b110
  } hts_hstate_t;

  typedef struct packed {
    logic home_at_en;
    logic go_zero;
    logic stop_var;
    logic [7:0] method;
    logic [31:0] offset;
    logic [31:0] max_search;
    logic [15:0] srch_v;
    logic [15:0] crawl_v;
    logic [15:0] run_v;
    logic [15:0] home_acc;
    logic [15:0] pos_v;
    logic [15:0] pos_acc;
    logic [3:0] jerk_sh;
    logic [31:0] remain_thr;
  } hts_cfg_t;

  localparam hts_cfg_t CFG_RST = '{
    home_at_en: 1'b0, go_zero: 1'b0, stop_var: 1'b0,
    method: M_NO_RUN, offset: 32'h0, max_search: 32'h00010000,
    srch_v: 16'h0100, crawl_v: 16'h0020, run_v: 16'h0400,
    home_acc: 16'h0010, pos_v: 16'h0400, pos_acc: 16'h0010,
    jerk_sh: 4'h0, remain_thr: 32'h0
  };

  typedef struct packed {
    hts_cfg_t cfg;
    logic [63:0][31:0] dest;
    hts_hstate_t hs;
    logic home_done;
    logic home_err;
    logic zero_pulse;
    logic moving;
    logic reached;
    logic remain;
    logic [5:0] sel;
    logic [5:0] act_sel;
    logic start_s;
    logic start_prev;
    logic en_prev;
    logic [7:0] tick_cnt;
    logic [31:0] stop_cnt;
    logic [31:0] start_pos;
    logic [31:0] origin;
    logic [31:0] target;
    logic signed [16:0] vel;
    logic [15:0] acc_cur;
    logic ack;
    logic [31:0] rdata;
  } hts_state_t;

endpackage

// ### verification/hts_monitor.sv
/*
  Port checker for hts_top, bound to every instance of it.
  Assumes one clock domain, synchronous reset RST and a bus master that holds each request.
*/
`timescale 1ns/10ps
module hts_monitor #(
  parameter logic [31:0] STOP_HOLD = 32'd20
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Bus side
  input wire logic [9:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [31:0] WRITEDATA,
  input wire logic WAITREQUEST,
  // Controller and axis
  input wire logic [5:0] DEST_SELECT_IN,
  input wire logic POSITION_START_IN,
  input wire logic ENABLE_IN,
  input wire logic STOP_DETECT_IN,
  // Watched outputs
  input wire logic signed [16:0] VEL_CMD_OUT,
  input wire logic [5:0] DEST_INDEX_OUT,
  input wire logic TARGET_REACHED_OUT,
  input wire logic HOMING_DONE_OUT,
  input wire logic HOMING_BUSY_OUT,
  input wire logic HOMING_ERROR_OUT,
  input wire logic ZERO_SET_OUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////
  // Counts edges with the stop held; it counts in every state, the design only during the search
  logic [31:0] stop_run_q;
  logic [31:0] stop_run_d;
  logic home_go;
  always_comb begin
    stop_run_d = STOP_DETECT_IN ? stop_run_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge CLK) begin
    stop_run_q <= RST ? 32'h0 : stop_run_d;
  end
  assign home_go = WRITE && !WAITREQUEST && ADDRESS == hts_pkg::A_CTRL && BYTEENABLE[0] &&
                   WRITEDATA[0];
  ////////////////////////////////////////
  property p_wait;
    (READ || WRITE) && WAITREQUEST |=> !WAITREQUEST;
  endproperty
  property p_sel;
    $rose(POSITION_START_IN) && ENABLE_IN && !HOMING_BUSY_OUT |->
      ##2 DEST_INDEX_OUT == $past(DEST_SELECT_IN, 2);
  endproperty
  property p_go;
    home_go && ENABLE_IN && !HOMING_BUSY_OUT |-> ##[1:2] (HOMING_BUSY_OUT || HOMING_ERROR_OUT);
  endproperty
  chk_wait_one: assert property (p_wait)
    else $error("bus access took more than one wait state");
  chk_sel_latch: assert property (p_sel)
    else $error("destination index differs from select at start");
  chk_dest_hold: assert property ($changed(DEST_INDEX_OUT) |-> $past(POSITION_START_IN, 2) && !$past(POSITION_START_IN, 3))
    else $error("destination index moved without a start edge");
  chk_reach_still: assert property ($rose(TARGET_REACHED_OUT) |-> VEL_CMD_OUT == 17'sd0 && !HOMING_BUSY_OUT)
    else $error("target reached with velocity not zero");
  chk_stop_hold: assert property (ZERO_SET_OUT && STOP_DETECT_IN |-> stop_run_q >= STOP_HOLD)
    else $error("stop taken before its hold time");
  chk_zero_pulse: assert property (ZERO_SET_OUT |=> !ZERO_SET_OUT && (HOMING_BUSY_OUT || HOMING_DONE_OUT))
    else $error("zero capture pulse wrong");
  chk_home_go: assert property (p_go)
    else $error("homing request not taken");
  // Done may rise with a run to zero still pending, so busy is not tested
  chk_done_clean: assert property ($rose(HOMING_DONE_OUT) |-> ZERO_SET_OUT && !HOMING_ERROR_OUT)
    else $error("homing done raised without zero capture or with error");
  cover property ($rose(HOMING_DONE_OUT));
  cover property ($rose(TARGET_REACHED_OUT));
  cover property ($rose(HOMING_ERROR_OUT));
endmodule // hts_monitor

bind hts_top hts_monitor #(.STOP_HOLD(STOP_HOLD)) hts_monitor_i (
  .CLK(CLK), .RST(RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
  .BYTEENABLE(BYTEENABLE), .WRITEDATA(WRITEDATA), .WAITREQUEST(WAITREQUEST),
  .DEST_SELECT_IN(DEST_SELECT_IN), .POSITION_START_IN(POSITION_START_IN),
  .ENABLE_IN(ENABLE_IN), .STOP_DETECT_IN(STOP_DETECT_IN), .VEL_CMD_OUT(VEL_CMD_OUT),
  .DEST_INDEX_OUT(DEST_INDEX_OUT), .TARGET_REACHED_OUT(TARGET_REACHED_OUT),
  .HOMING_DONE_OUT(HOMING_DONE_OUT), .HOMING_BUSY_OUT(HOMING_BUSY_OUT),
  .HOMING_ERROR_OUT(HOMING_ERROR_OUT), .ZERO_SET_OUT(ZERO_SET_OUT));

// ### verification/hts_axis_model.sv
/*
  Axis model: integrates the velocity command into an encoder position and
  makes limit switches, a mechanical stop and an index mark from it.
  Assumes one profile step of the axis every TICK clocks.
*/
`timescale 1ns/10ps
module hts_axis_model #(
  parameter int TICK = 250,
  parameter int LIM = 5000,
  parameter int STOP_AT = 3000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command and setup
  input wire logic signed [16:0] vel,
  input wire logic lim_en,
  input wire logic stop_en,
  // Feedback
  output logic signed [31:0] pos,
  output logic neg_lim,
  output logic pos_lim,
  output logic stop_hit,
  output logic index
);
  int tick_cnt;
  logic signed [31:0] nxt;
  ////////////////////////////////////////
  always_comb begin
    nxt = pos + 32'(vel);
    // The stop is rigid: the axis cannot pass it
    if (stop_en && nxt < -STOP_AT) begin
      nxt = -STOP_AT;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      pos <= 32'sh0;
      tick_cnt <= 0;
    end else if (tick_cnt == TICK - 1) begin
      tick_cnt <= 0;
      pos <= nxt;
    end else begin
      tick_cnt <= tick_cnt + 1;
    end
  end
  assign neg_lim = lim_en && pos <= -LIM;
  assign pos_lim = lim_en && pos >= LIM;
  assign stop_hit = stop_en && pos <= -STOP_AT && vel <= 0;
  assign index = pos[9:8] == 2'b00;
endmodule // hts_axis_model

// ### verification/homing_and_target_start_test.sv
/*
  Self-checking bench for hts_top with the axis model on its far side.
  Assumes the one-wait-state bus answer and a stop hold shortened to 20.
*/
`timescale 1ns/10ps
module homing_and_target_start_test;
  localparam logic [31:0] OFF = 32'h64;
  logic clk;
  logic rst;
  logic [9:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic [5:0] dest_sel;
  logic start;
  logic enable;
  logic neg_lim;
  logic pos_lim;
  logic stop_hit;
  logic index;
  logic signed [31:0] pos;
  logic signed [16:0] vel;
  logic [31:0] target;
  logic [5:0] dest_idx;
  logic reached;
  logic remain;
  logic done;
  logic busy;
  logic err;
  logic zero_set;
  logic lim_en;
  logic stop_en;
  logic wr_n;
  logic [31:0] rd_n;
  logic seen_rem;
  logic [16:0] peak;
  int num_errors;
  int total_checks;
  hts_top #(.STOP_HOLD(32'd20)) hts_top_i (
    .CLK(clk), .RST(rst), .ADDRESS(address), .READ(read), .WRITE(write),
    .BYTEENABLE(4'hf), .WRITEDATA(writedata), .READDATA(readdata),
    .WAITREQUEST(waitrequest), .DEST_SELECT_IN(dest_sel), .POSITION_START_IN(start),
    .ENABLE_IN(enable), .NEG_LIMIT_IN(neg_lim), .POS_LIMIT_IN(pos_lim),
    .STOP_DETECT_IN(stop_hit), .INDEX_PULSE_IN(index), .ACTUAL_POS_IN(pos),
    .VEL_CMD_OUT(vel), .TARGET_POS_OUT(target), .DEST_INDEX_OUT(dest_idx),
    .TARGET_REACHED_OUT(reached), .REMAIN_DIST_OUT(remain), .HOMING_DONE_OUT(done),
    .HOMING_BUSY_OUT(busy), .HOMING_ERROR_OUT(err), .ZERO_SET_OUT(zero_set));
  hts_axis_model hts_axis_model_i (.clk(clk), .rst(rst), .vel(vel), .lim_en(lim_en),
    .stop_en(stop_en), .pos(pos), .neg_lim(neg_lim), .pos_lim(pos_lim),
    .stop_hit(stop_hit), .index(index));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Mid-cycle copies equal what the next rising edge samples
  always @(negedge clk) begin
    wr_n = waitrequest;
    rd_n = readdata;
    if (remain === 1'b1) seen_rem = 1'b1;
    if (busy === 1'b1 && 17'(vel[16] ? -vel : vel) > peak) peak = 17'(vel[16] ? -vel : vel);
  end
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    address <= a;
    read <= !w;
    write <= w;
    writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (wr_n !== 1'b0 && n < 50);
    if (n >= 50) begin
      num_errors++;
      tally_and_finish();
    end
    rd = rd_n;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  // Bounded wait: 0 homing done, 1 homing error, 2 target reached, 3 homing idle
  task automatic wait_for(input int k, input int lim);
    int n;
    n = 0;
    while (!(k == 0 ? done === 1'b1 : k == 1 ? err === 1'b1
             : k == 2 ? reached === 1'b1 : busy === 1'b0) && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      tally_and_finish();
    end
    @(posedge clk);
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    logic [7:0] codes [7];
    codes = '{hts_pkg::M_NEG_IDX, hts_pkg::M_POS_IDX, hts_pkg::M_NEG_SW, hts_pkg::M_POS_SW,
              hts_pkg::M_IDX_NEG, hts_pkg::M_IDX_POS, hts_pkg::M_NO_RUN};
    bus(1'b0, hts_pkg::A_METHOD, 32'h0, d);
    check("method reset", d, 32'h23);
    bus(1'b0, hts_pkg::A_SRCH_V, 32'h0, d);
    check("search speed", d, 32'h100);
    bus(1'b0, hts_pkg::A_CRAWL_V, 32'h0, d);
    check("crawl speed", d, 32'h20);
    bus(1'b0, 10'h3fc, 32'h0, d);
    check("unmapped", d, 32'h0);
    wr(hts_pkg::A_ORIGIN, 32'h1234);
    bus(1'b0, hts_pkg::A_ORIGIN, 32'h0, d);
    check("origin read only", d, 32'h0);
    foreach (codes[i]) begin
      wr(hts_pkg::A_METHOD, 32'(codes[i]));
      bus(1'b0, hts_pkg::A_METHOD, 32'h0, d);
      check("method code", d, 32'(codes[i]));
    end
  endtask
  task automatic t_no_run();
    logic [31:0] d;
    wr(hts_pkg::A_OFFSET, OFF);
    wr(hts_pkg::A_CTRL, 32'h2);
    enable <= 1'b0;
    repeat (3) @(posedge clk);
    enable <= 1'b1;
    wait_for(0, 50);
    check("done at enable", 32'(done), 32'h1);
    bus(1'b0, hts_pkg::A_ORIGIN, 32'h0, d);
    check("no run origin", d, OFF);
    check("no run motion", pos, 32'h0);
    bus(1'b0, hts_pkg::A_STATUS, 32'h0, d);
    check("status done", d, 32'h1);
    wr(hts_pkg::A_CTRL, 32'h0);
  endtask
  task automatic t_bad_code();
    wr(hts_pkg::A_METHOD, 32'h05);
    wr(hts_pkg::A_CTRL, 32'h1);
    wait_for(1, 20);
    check("bad code done", 32'(done), 32'h0);
    check("bad code vel", 32'(vel), 32'h0);
  endtask
  task automatic t_move();
    wr(hts_pkg::A_REMAIN, 32'h100);
    wr(10'h114, 32'h300);
    dest_sel <= 6'h05;
    @(posedge clk);
    start <= 1'b1;
    repeat (2) @(posedge clk);
    dest_sel <= 6'h3f;
    repeat (2) @(posedge clk);
    check("dest index", 32'(dest_idx), 32'h5);
    check("target", target, OFF + 32'h300);
    start <= 1'b0;
    wait_for(2, 60000);
    check("end velocity", 32'(vel), 32'h0);
    check("remain seen", 32'(seen_rem), 32'h1);
  endtask
  task automatic t_stop17();
    logic [31:0] d;
    stop_en <= 1'b1;
    wr(hts_pkg::A_METHOD, 32'(hts_pkg::M_NEG_SW));
    wr(hts_pkg::A_CTRL, 32'h9);
    wait_for(0, 60000);
    bus(1'b0, hts_pkg::A_ORIGIN, 32'h0, d);
    check("stop origin", d, 32'(-3000) + OFF);
    stop_en <= 1'b0;
  endtask
  task automatic t_lim17();
    logic [31:0] d;
    logic signed [31:0] o;
    lim_en <= 1'b1;
    peak = 17'h0;
    wr(hts_pkg::A_CTRL, 32'h1);
    wait_for(0, 80000);
    bus(1'b0, hts_pkg::A_ORIGIN, 32'h0, d);
    o = $signed(d) - $signed(OFF);
    check("limit origin", 32'(o > -5000 && o <= -4936), 32'h1);
    check("homing speed", 32'(peak <= 17'h100), 32'h1);
  endtask
  task automatic t_max();
    wr(hts_pkg::A_MAXSRCH, 32'h40);
    wr(hts_pkg::A_METHOD, 32'(hts_pkg::M_POS_SW));
    wr(hts_pkg::A_CTRL, 32'h1);
    wait_for(1, 20000);
    check("search abort done", 32'(done), 32'h0);
  endtask
  // No-run capture, then the run to the new zero must settle on it
  task automatic t_go_zero();
    logic [31:0] d;
    logic signed [31:0] o;
    wr(hts_pkg::A_METHOD, 32'(hts_pkg::M_NO_RUN));
    wr(hts_pkg::A_CTRL, 32'h5);
    wait_for(3, 20000);
    bus(1'b0, hts_pkg::A_ORIGIN, 32'h0, d);
    o = pos - $signed(d);
    check("go zero end", 32'(o >= -64 && o <= 64 && vel == 17'sh0), 32'h1);
    check("go zero done", 32'(done), 32'h1);
  endtask
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    address = 10'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    dest_sel = 6'h0;
    start = 1'b0;
    enable = 1'b1;
    lim_en = 1'b0;
    stop_en = 1'b0;
    seen_rem = 1'b0;
    peak = 17'h0;
    num_errors = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_no_run();
    t_bad_code();
    t_move();
    t_stop17();
    t_lim17();
    t_max();
    t_go_zero();
    tally_and_finish();
  end
endmodule // homing_and_target_start_test
